//--- logic/sst_supervisor.sv
// Secondary supervisor: protection, fan control, task scheduling, telemetry maps
`timescale 1ns/1ps
`default_nettype none
module sst_supervisor
  import sst_pkg::*;
#(
  parameter longint unsigned OC_TIMEOUT = OC_TIMEOUT_CYC,
  parameter logic [15:0] DERATE_GAIN = 16'h0001
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Measurements
  input wire logic [WORD_W-1:0] loadCurrent,
  input wire logic [WORD_W-1:0] outVoltage,
  input wire logic [WORD_W-1:0] maxCurrentLimit,
  input wire logic [WORD_W-1:0] tempA,
  input wire logic [WORD_W-1:0] tempB,
  input wire logic [WORD_W-1:0] tempC,
  input wire logic [WORD_W-1:0] pfcCtrlFlag,
  // Other secondary values for the status table
  input wire logic [WORD_W-1:0] miscIdx,
  input wire logic [4:0] miscAddr,
  input wire logic miscWr,
  // PWM special event (asynchronous pin)
  input wire logic pwmEventPin,
  // Protection and fan outputs
  output logic outputEnable,
  output logic fanHalf,
  output logic fanFull,
  output logic [WORD_W-1:0] currentLimit,
  // Scheduler outputs
  output logic runCurrentLoop,
  output logic runVoltageLoop,
  output logic triggerPhase,
  output logic medTick,
  output logic runBackground,
  // Primary record input (word stream, index order 0..9)
  input wire logic priValid,
  output logic priReady,
  input wire logic [WORD_W-1:0] priData,
  // Secondary record output (3 words)
  output logic secValid,
  input wire logic secReady,
  output logic [WORD_W-1:0] secData,
  // I2C client table read
  input wire logic [4:0] statAddr,
  output logic [WORD_W-1:0] statData
);
  localparam int unsigned OCW = 40;
  localparam logic [OCW-1:0] OC_LIM = OCW'(OC_TIMEOUT);
  localparam logic [15:0] MED_LIM = 16'(MED_TICK_CYC - 1);

  function automatic logic [WORD_W-1:0] max2(input logic [WORD_W-1:0] a,
                                             input logic [WORD_W-1:0] b);
    max2 = (a > b) ? a : b;
  endfunction : max2

  // Three-stage pin synchroniser
  logic [2:0] evSync_ff, nxt_evSync;
  logic evLevel_ff, nxt_evLevel;
  logic evPulse;
  always_comb begin
    nxt_evSync = {evSync_ff[1:0], pwmEventPin};
    nxt_evLevel = (evSync_ff[1] == evSync_ff[2]) ? evSync_ff[2] : evLevel_ff;
  end
  assign evPulse = nxt_evLevel && !evLevel_ff;

  logic [WORD_W-1:0] hottest;
  assign hottest = max2(max2(tempA, tempB), tempC);

  // Derating from primary RMS voltage
  logic [WORD_W-1:0] priWords [PRI_WORDS];
  logic [WORD_W-1:0] derate, limitCalc;
  logic [31:0] derateProd;
  always_comb begin
    derateProd = 32'h0;
    if (priWords[PRI_VRMS] < DERATE_VAC) begin
      derateProd = (DERATE_VAC - priWords[PRI_VRMS]) * DERATE_GAIN;
    end
    derate = (derateProd > {16'h0, maxCurrentLimit}) ? maxCurrentLimit : derateProd[15:0];
    limitCalc = maxCurrentLimit - derate;
  end

  // Protection and fan state
  logic [OCW-1:0] ocCnt_ff, nxt_ocCnt;
  logic [WORD_W-1:0] limCnt_ff, nxt_limCnt;
  logic ocTrip_ff, nxt_ocTrip, thTrip_ff, nxt_thTrip;
  sst_fan_t fan_ff, nxt_fan;
  logic outEn_ff, nxt_outEn;
  logic fanHalf_ff, fanFull_ff;
  logic [WORD_W-1:0] lim_ff;
  always_comb begin
    nxt_ocCnt = ocCnt_ff;
    nxt_ocTrip = ocTrip_ff;
    nxt_limCnt = limCnt_ff;
    if (loadCurrent > limitCalc) begin
      if (ocCnt_ff >= OC_LIM) begin
        nxt_ocTrip = 1'b1;
      end else begin
        nxt_ocCnt = ocCnt_ff + 1'b1;
      end
      if (ocCnt_ff == '0) begin
        nxt_limCnt = limCnt_ff + 1'b1;
      end
    end else begin
      nxt_ocCnt = '0;
    end
    nxt_thTrip = thTrip_ff || (hottest > TEMP_SHUTDOWN);
    nxt_fan = fan_ff;
    if (hottest < TEMP_FAN_OFF) begin
      nxt_fan = SST_FAN_OFF;
    end else if (hottest >= TEMP_FAN_FULL) begin
      nxt_fan = SST_FAN_FULL;
    end else if (hottest >= TEMP_FAN_HALF) begin
      nxt_fan = SST_FAN_HALF;
    end
    nxt_outEn = !(nxt_ocTrip || nxt_thTrip);
  end

  // Scheduler state
  logic [15:0] medCnt_ff, nxt_medCnt;
  logic medPend_ff, nxt_medPend, hiPend_ff, nxt_hiPend;
  logic loopSel_ff, nxt_loopSel, phase_ff, nxt_phase;
  sst_task_t nxt_task;
  logic runV_ff, runC_ff, medRun_ff, bgRun_ff;
  logic tick;
  assign tick = (medCnt_ff == MED_LIM);
  always_comb begin
    nxt_medCnt = tick ? 16'h0 : medCnt_ff + 1'b1;
    nxt_hiPend = hiPend_ff || evPulse;
    nxt_medPend = medPend_ff || tick;
    nxt_loopSel = loopSel_ff;
    nxt_phase = phase_ff;
    nxt_task = SST_TASK_IDLE;
    if (hiPend_ff) begin
      nxt_task = SST_TASK_HIGH;
      nxt_hiPend = evPulse;
      nxt_loopSel = !loopSel_ff;
      nxt_phase = !phase_ff;
    end else if (medPend_ff) begin
      nxt_task = SST_TASK_MED;
      nxt_medPend = tick;
    end else if (!evPulse && !tick) begin
      nxt_task = SST_TASK_LOW;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evSync_ff <= 3'h0;
      evLevel_ff <= 1'b0;
      ocCnt_ff <= '0;
      limCnt_ff <= ZERO_W;
      ocTrip_ff <= 1'b0;
      thTrip_ff <= 1'b0;
      fan_ff <= SST_FAN_OFF;
      outEn_ff <= 1'b0;
      fanHalf_ff <= 1'b0;
      fanFull_ff <= 1'b0;
      lim_ff <= ZERO_W;
      medCnt_ff <= 16'h0;
      medPend_ff <= 1'b0;
      hiPend_ff <= 1'b0;
      loopSel_ff <= 1'b0;
      phase_ff <= 1'b0;
      runV_ff <= 1'b0;
      runC_ff <= 1'b0;
      medRun_ff <= 1'b0;
      bgRun_ff <= 1'b0;
    end else begin
      evSync_ff <= nxt_evSync;
      evLevel_ff <= nxt_evLevel;
      ocCnt_ff <= nxt_ocCnt;
      limCnt_ff <= nxt_limCnt;
      ocTrip_ff <= nxt_ocTrip;
      thTrip_ff <= nxt_thTrip;
      fan_ff <= nxt_fan;
      outEn_ff <= nxt_outEn;
      fanHalf_ff <= (nxt_fan == SST_FAN_HALF);
      fanFull_ff <= (nxt_fan == SST_FAN_FULL);
      lim_ff <= limitCalc;
      medCnt_ff <= nxt_medCnt;
      medPend_ff <= nxt_medPend;
      hiPend_ff <= nxt_hiPend;
      loopSel_ff <= nxt_loopSel;
      phase_ff <= nxt_phase;
      runV_ff <= (nxt_task == SST_TASK_HIGH) && !loopSel_ff;
      runC_ff <= (nxt_task == SST_TASK_HIGH) && loopSel_ff;
      medRun_ff <= (nxt_task == SST_TASK_MED);
      bgRun_ff <= (nxt_task == SST_TASK_LOW);
    end
  end

  assign outputEnable = outEn_ff;
  assign fanHalf = fanHalf_ff;
  assign fanFull = fanFull_ff;
  assign currentLimit = lim_ff;
  assign runVoltageLoop = runV_ff;
  assign runCurrentLoop = runC_ff;
  assign triggerPhase = phase_ff;
  assign medTick = medRun_ff;
  assign runBackground = bgRun_ff;

  logic [3:0] priIdx_ff, nxt_priIdx;
  logic priTake, priRdy_ff;
  // Ready from a flop; rises one edge after reset release
  assign priReady = priRdy_ff;
  assign priTake = priValid && priRdy_ff;
  always_comb begin
    nxt_priIdx = priIdx_ff;
    if (priTake) begin
      nxt_priIdx = (priIdx_ff == 4'(PRI_WORDS - 1)) ? 4'h0 : priIdx_ff + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      priIdx_ff <= 4'h0;
      priRdy_ff <= 1'b0;
      for (int i = 0; i < PRI_WORDS; i++) begin
        priWords[i] <= ZERO_W;
      end
    end else begin
      priIdx_ff <= nxt_priIdx;
      priRdy_ff <= 1'b1;
      if (priTake) begin
        priWords[priIdx_ff] <= priData;
      end
    end
  end

  // three-word record into the FIFO on each medium tick
  logic [1:0] secIdx_ff, nxt_secIdx;
  logic secBusy_ff, nxt_secBusy;
  logic fifoInReady;
  logic [WORD_W-1:0] secWord;
  always_comb begin
    secWord = pfcCtrlFlag;
    if (secIdx_ff == SEC_VOUT) begin
      secWord = outVoltage;
    end else if (secIdx_ff == SEC_IOUT) begin
      secWord = loadCurrent;
    end
    nxt_secIdx = secIdx_ff;
    nxt_secBusy = secBusy_ff;
    if (!secBusy_ff) begin
      nxt_secBusy = tick;
    end else if (fifoInReady) begin
      nxt_secIdx = (secIdx_ff == SEC_CTRL) ? SEC_VOUT : secIdx_ff + 1'b1;
      nxt_secBusy = (secIdx_ff != SEC_CTRL);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      secIdx_ff <= SEC_VOUT;
      secBusy_ff <= 1'b0;
    end else begin
      secIdx_ff <= nxt_secIdx;
      secBusy_ff <= nxt_secBusy;
    end
  end

  // Output staging register so outputs come from flops
  logic fifoOutValid, stageValid_ff, nxt_stageValid, fifoPop;
  logic [WORD_W-1:0] fifoOutData, stageData_ff, nxt_stageData;
  assign fifoPop = fifoOutValid && (!stageValid_ff || secReady);
  always_comb begin
    nxt_stageValid = stageValid_ff;
    nxt_stageData = stageData_ff;
    if (fifoPop) begin
      nxt_stageValid = 1'b1;
      nxt_stageData = fifoOutData;
    end else if (secReady) begin
      nxt_stageValid = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stageValid_ff <= 1'b0;
      stageData_ff <= ZERO_W;
    end else begin
      stageValid_ff <= nxt_stageValid;
      stageData_ff <= nxt_stageData;
    end
  end
  assign secValid = stageValid_ff;
  assign secData = stageData_ff;

  sst_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(secBusy_ff),
    .inReady(fifoInReady),
    .inData(secWord),
    .outValid(fifoOutValid),
    .outReady(!stageValid_ff || secReady),
    .outData(fifoOutData)
  );

  // status table, unused words read zero
  logic [WORD_W-1:0] stat [STAT_WORDS];
  logic [WORD_W-1:0] statRd_ff, nxt_statRd;
  logic [WORD_W-1:0] misc [STAT_WORDS];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < STAT_WORDS; i++) begin
        misc[i] <= ZERO_W;
      end
    end else if (miscWr) begin
      misc[miscAddr] <= miscIdx;
    end
  end
  always_comb begin
    for (int i = 0; i < STAT_WORDS; i++) begin
      stat[i] = ZERO_W;
    end
    stat[ST_VRMS] = priWords[PRI_VRMS];
    stat[ST_IIN] = priWords[PRI_IIN];
    stat[ST_PER] = priWords[PRI_PER];
    stat[ST_BULK] = priWords[PRI_BULK];
    stat[ST_PTEMP] = priWords[PRI_TEMP];
    for (int i = 0; i < 5; i++) begin
      stat[int'(ST_GAIN0) + i] = priWords[int'(PRI_PER) + 1 + i];
    end
    stat[ST_LS_IN] = misc[ST_LS_IN];
    stat[ST_LS_OUT] = misc[ST_LS_OUT];
    stat[ST_LS_INT] = misc[ST_LS_INT];
    stat[ST_DPER] = misc[ST_DPER];
    stat[ST_SR] = misc[ST_SR];
    stat[ST_VOUT] = outVoltage;
    stat[ST_IOUT] = loadCurrent;
    stat[ST_T1] = tempA;
    stat[ST_T2] = tempB;
    for (int i = 0; i < 6; i++) begin
      stat[int'(ST_DGAIN0) + i] = misc[int'(ST_DGAIN0) + i];
    end
    stat[ST_FAULT] = {13'h0, thTrip_ff, ocTrip_ff, !outEn_ff};
    stat[ST_ILIM] = lim_ff;
    stat[ST_LIMCNT] = limCnt_ff;
    nxt_statRd = stat[statAddr];
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      statRd_ff <= ZERO_W;
    end else begin
      statRd_ff <= nxt_statRd;
    end
  end
  assign statData = statRd_ff;
endmodule : sst_supervisor
`default_nettype wire

//--- logic/sst_pkg.sv
// Package of constants and types for the secondary supervisor telemetry block
package sst_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned OC_TIMEOUT_S = 5;
  localparam longint unsigned OC_TIMEOUT_CYC = longint'(OC_TIMEOUT_S) * CLK_HZ;
  localparam int unsigned MED_TICK_HZ = 4800;
  localparam int unsigned MED_TICK_CYC = CLK_HZ / MED_TICK_HZ;
  localparam int unsigned WORD_W = 16;
  localparam logic [15:0] TEMP_FAN_OFF = 16'h003c;
  localparam logic [15:0] TEMP_FAN_HALF = 16'h003f;
  localparam logic [15:0] TEMP_FAN_FULL = 16'h0046;
  localparam logic [15:0] TEMP_SHUTDOWN = 16'h0050;
  localparam logic [15:0] DERATE_VAC = 16'h006e;
  localparam logic [15:0] ZERO_W = 16'h0000;
  localparam int unsigned PRI_WORDS = 10;
  localparam int unsigned SEC_WORDS = 3;
  localparam int unsigned STAT_WORDS = 32;
  localparam logic [3:0] PRI_BULK = 4'h0;
  localparam logic [3:0] PRI_VRMS = 4'h1;
  localparam logic [3:0] PRI_IIN = 4'h2;
  localparam logic [3:0] PRI_TEMP = 4'h3;
  localparam logic [3:0] PRI_PER = 4'h4;
  localparam logic [3:0] PRI_STAT = 4'h9;
  localparam logic [1:0] SEC_VOUT = 2'h0;
  localparam logic [1:0] SEC_IOUT = 2'h1;
  localparam logic [1:0] SEC_CTRL = 2'h2;
  localparam logic [4:0] ST_VRMS = 5'h00;
  localparam logic [4:0] ST_IIN = 5'h01;
  localparam logic [4:0] ST_PER = 5'h02;
  localparam logic [4:0] ST_BULK = 5'h03;
  localparam logic [4:0] ST_PTEMP = 5'h04;
  localparam logic [4:0] ST_GAIN0 = 5'h05;
  localparam logic [4:0] ST_PSTAT = 5'h09;
  localparam logic [4:0] ST_LS_IN = 5'h0b;
  localparam logic [4:0] ST_LS_OUT = 5'h0c;
  localparam logic [4:0] ST_LS_INT = 5'h0d;
  localparam logic [4:0] ST_DPER = 5'h10;
  localparam logic [4:0] ST_SR = 5'h11;
  localparam logic [4:0] ST_VOUT = 5'h12;
  localparam logic [4:0] ST_IOUT = 5'h13;
  localparam logic [4:0] ST_T1 = 5'h14;
  localparam logic [4:0] ST_T2 = 5'h15;
  localparam logic [4:0] ST_DGAIN0 = 5'h17;
  localparam logic [4:0] ST_PRIC = 5'h1b;
  localparam logic [4:0] ST_PRICF = 5'h1c;
  localparam logic [4:0] ST_FAULT = 5'h1d;
  localparam logic [4:0] ST_ILIM = 5'h1e;
  localparam logic [4:0] ST_LIMCNT = 5'h1f;
  localparam int unsigned FIFO_DEPTH = 16;
  typedef enum logic [1:0] {SST_FAN_OFF, SST_FAN_HALF, SST_FAN_FULL} sst_fan_t;
  typedef enum {SST_TASK_IDLE, SST_TASK_HIGH, SST_TASK_MED, SST_TASK_LOW} sst_task_t;
endpackage : sst_pkg

//--- logic/sst_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sst_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
  logic [AW:0] count_ff, nxt_count;
  logic doWr, doRd;

  assign inReady = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData = mem[rdPtr_ff];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  always_comb begin
    nxt_wrPtr = doWr ? wrPtr_ff + 1'b1 : wrPtr_ff;
    nxt_rdPtr = doRd ? rdPtr_ff + 1'b1 : rdPtr_ff;
    nxt_count = count_ff;
    if (doWr && !doRd) begin
      nxt_count = count_ff + 1'b1;
    end else if (doRd && !doWr) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end

  // Storage has no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_ff] <= inData;
    end
  end
endmodule : sst_fifo
`default_nettype wire

//--- testbench/sst_checker.sv
// Checker of supervisor protection, fan and scheduling behaviour
`timescale 1ns/1ps
`default_nettype none
module sst_checker
  import sst_pkg::*;
#(
  parameter longint unsigned OC_TIMEOUT = OC_TIMEOUT_CYC
) (
  // Inputs
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WORD_W-1:0] loadCurrent,
  input wire logic [WORD_W-1:0] tempA,
  input wire logic [WORD_W-1:0] tempB,
  input wire logic [WORD_W-1:0] tempC,
  input wire logic [4:0] statAddr,
  // Outputs
  input wire logic outputEnable,
  input wire logic fanHalf,
  input wire logic fanFull,
  input wire logic [WORD_W-1:0] currentLimit,
  input wire logic runCurrentLoop,
  input wire logic runVoltageLoop,
  input wire logic medTick,
  input wire logic runBackground,
  input wire logic [WORD_W-1:0] statData
);
  // Late service by a high task may shift a tick a few cycles
  localparam int GAP_LO = MED_TICK_CYC - 8;
  localparam int GAP_HI = MED_TICK_CYC + 8;
  logic [WORD_W-1:0] hot;
  logic hiRun;
  longint unsigned ocCnt_ff;
  int gap_ff;
  logic lastV_ff;
  logic hotSeen_ff;
  logic tickSeen_ff;
  assign hiRun = runVoltageLoop | runCurrentLoop;
  always_comb begin
    hot = tempA;
    if (tempB > hot) hot = tempB;
    if (tempC > hot) hot = tempC;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ocCnt_ff <= 0;
      gap_ff <= 0;
      lastV_ff <= 1'b0;
      hotSeen_ff <= 1'b0;
      tickSeen_ff <= 1'b0;
    end else begin
      ocCnt_ff <= (loadCurrent > currentLimit) ? ocCnt_ff + 1 : 0;
      gap_ff <= medTick ? 0 : gap_ff + 1;
      tickSeen_ff <= tickSeen_ff | medTick;
      hotSeen_ff <= hotSeen_ff | (hot > TEMP_SHUTDOWN);
      if (hiRun) lastV_ff <= runVoltageLoop;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_fans_off: assert property ((hot < TEMP_FAN_OFF)[*4] |-> !fanHalf && !fanFull)
    else $error("fans running while cool");
  chk_fan_half: assert property ((hot >= TEMP_FAN_HALF && hot < TEMP_FAN_FULL)[*4]
    |-> fanHalf && !fanFull) else $error("fans not at half speed");
  chk_fan_full: assert property ((hot >= TEMP_FAN_FULL && hot <= TEMP_SHUTDOWN)[*4]
    |-> fanFull && !fanHalf) else $error("fans not at full speed");
  chk_fan_hold: assert property ((hot >= TEMP_FAN_OFF && hot < TEMP_FAN_HALF)[*4]
    |-> $stable(fanHalf) && $stable(fanFull)) else $error("fan command moved in band");
  chk_thermal_trip: assert property ((hot > TEMP_SHUTDOWN)[*4] |-> !outputEnable)
    else $error("output on while overheated");
  chk_oc_trip: assert property (ocCnt_ff == OC_TIMEOUT + 4 |-> !outputEnable)
    else $error("output on after overcurrent timeout");
  chk_oc_early: assert property ($fell(outputEnable) |-> ocCnt_ff >= OC_TIMEOUT
    || hotSeen_ff || hot > TEMP_SHUTDOWN) else $error("output cut before timeout");
  chk_loop_alternate: assert property (hiRun |-> !(runVoltageLoop && runCurrentLoop)
    && runVoltageLoop != lastV_ff) else $error("loops did not alternate");
  chk_med_gap: assert property (medTick && tickSeen_ff |-> gap_ff >= GAP_LO
    && gap_ff <= GAP_HI) else $error("medium tick period wrong");
  chk_bg_yields: assert property (hiRun || medTick |-> !$past(runBackground))
    else $error("background ran with a task pending");
  chk_unused_zero: assert property (statAddr inside {5'h0a, 5'h0e, 5'h0f, 5'h16}
    |=> statData == ZERO_W) else $error("unused status word not zero");
  cover property (hiRun);
  cover property ($fell(outputEnable));
  cover property (fanFull);
endmodule : sst_checker
bind sst_supervisor sst_checker #(.OC_TIMEOUT(OC_TIMEOUT)) chk (.*);
`default_nettype wire

//--- testbench/sst_primary_model.sv
// Model of the primary-side controller at the record stream ports
`timescale 1ns/1ps
`default_nettype none
module sst_primary_model
  import sst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic sendGo,
  input wire logic stall,
  input wire logic [WORD_W-1:0] vrms,
  output logic [47:0] rxWords,
  output logic [7:0] rxCount,
  // Record streams
  output logic priValid,
  input wire logic priReady,
  output logic [WORD_W-1:0] priData,
  input wire logic secValid,
  output logic secReady,
  input wire logic [WORD_W-1:0] secData
);
  logic [3:0] idx;
  function automatic logic [WORD_W-1:0] wordAt(input logic [3:0] i);
    return (i == PRI_VRMS) ? vrms : 16'h1000 + {12'h000, i};
  endfunction : wordAt
  always @(posedge clk) begin
    if (!rst_n) begin
      priValid <= 1'b0;
      priData <= 16'h5a5a;
      idx <= 4'h0;
      secReady <= 1'b0;
      rxWords <= 48'h0;
      rxCount <= 8'h00;
    end else begin
      secReady <= !stall;
      if (priValid && priReady) begin
        idx <= idx + 4'h1;
        priData <= wordAt(idx + 4'h1);
        if (idx == PRI_STAT) begin
          priValid <= 1'b0;
          // Released line must not keep the last word
          priData <= ~priData;
          idx <= 4'h0;
        end
      end else if (!priValid && sendGo) begin
        priValid <= 1'b1;
        priData <= wordAt(4'h0);
      end
      if (secValid && secReady) begin
        rxWords <= {rxWords[31:0], secData};
        rxCount <= rxCount + 8'h01;
      end
    end
  end
endmodule : sst_primary_model
`default_nettype wire

//--- testbench/sst_supervisor_test.sv
// Self-checking bench for the secondary supervisor
`timescale 1ns/1ps
`default_nettype none
module sst_supervisor_test import sst_pkg::*;;
  localparam longint unsigned OC_T = 50;
  localparam logic [15:0] GAIN = 16'h0002;
  localparam logic [15:0] MAXLIM = 16'h0100;
  logic clk, rst_n, miscWr, pwmEventPin, secReady, priValid, priReady, secValid, sendGo, stall;
  logic [WORD_W-1:0] loadCurrent, outVoltage, maxCurrentLimit, tempA, tempB, tempC;
  logic [WORD_W-1:0] pfcCtrlFlag, miscIdx, priData, secData, currentLimit, statData, vrms, d;
  logic [4:0] miscAddr, statAddr;
  logic outputEnable, fanHalf, fanFull, runCurrentLoop, runVoltageLoop, triggerPhase;
  logic medTick, runBackground;
  logic [47:0] rxWords;
  logic [7:0] rxCount;
  int n_fail = 0;
  int checks = 0;
  int nV = 0;
  int nC = 0;
  sst_supervisor #(.OC_TIMEOUT(OC_T), .DERATE_GAIN(GAIN)) uut (.*);
  sst_primary_model pm (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (runVoltageLoop === 1'b1) nV++;
    if (runCurrentLoop === 1'b1) nC++;
  end
  task automatic conclude();
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic doReset();
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(3);
    @(negedge clk);
  endtask : doReset
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    statAddr <= a;
    @(posedge clk);
    @(negedge clk);
    d = statData;
  endtask : rd
  task automatic testSched();
    logic ph;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      ph = triggerPhase;
      @(posedge clk);
      pwmEventPin <= 1'b1;
      cyc(3);
      pwmEventPin <= 1'b0;
      cyc(30);
      @(negedge clk);
      chk("voltage runs", k / 2 + 1, nV);
      chk("current runs", (k + 1) / 2, nC);
      chk("trigger phase", !ph, triggerPhase);
      chk("background", 1, runBackground);
    end
  endtask : testSched
  task automatic fan(input logic [15:0] a, b, c, input logic [1:0] e);
    @(posedge clk);
    {tempA, tempB, tempC} <= {a, b, c};
    cyc(6);
    @(negedge clk);
    chk("fan half and full", e, {fanHalf, fanFull});
  endtask : fan
  task automatic testFans();
    fan(16'h0032, 16'h000a, 16'h0014, 2'b00);
    fan(16'h000a, 16'h0041, 16'h0014, 2'b10);
    fan(16'h003d, 16'h000a, 16'h000a, 2'b10);
    fan(16'h000a, 16'h000a, 16'h004b, 2'b01);
    fan(16'h003d, 16'h003d, 16'h003d, 2'b01);
    fan(16'h003b, 16'h0000, 16'h0000, 2'b00);
    fan(16'h003e, 16'h0000, 16'h0000, 2'b00);
    fan(16'h0000, 16'h003f, 16'h0000, 2'b10);
    fan(16'h0000, 16'h0000, 16'h0046, 2'b01);
    fan(16'h0050, 16'h0000, 16'h0000, 2'b01);
    chk("output at limit temp", 1, outputEnable);
    fan(16'h0020, 16'h0020, 16'h0020, 2'b00);
  endtask : testFans
  task automatic sendRec(input logic [15:0] v);
    @(posedge clk);
    vrms <= v;
    sendGo <= 1'b1;
    @(posedge clk);
    sendGo <= 1'b0;
    cyc(15);
    @(negedge clk);
  endtask : sendRec
  task automatic testTables();
    logic [3:0] src [10] = '{4'h1, 4'h2, 4'h4, 4'h0, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
    logic [4:0] gap [4] = '{5'h0a, 5'h0e, 5'h0f, 5'h16};
    sendRec(16'h0064);
    chk("derated limit", MAXLIM - GAIN * (DERATE_VAC - 16'h0064), currentLimit);
    for (int i = 0; i < 10; i++) begin
      rd(5'(i));
      chk("status word", (src[i] == PRI_VRMS) ? 16'h0064 : 16'h1000 + src[i], d);
    end
    // Second write lands in a hidden word that must still read zero
    @(posedge clk);
    {miscWr, miscAddr, miscIdx} <= {1'b1, ST_LS_IN, 16'h0b0b};
    @(posedge clk);
    miscAddr <= 5'h0e;
    @(posedge clk);
    miscWr <= 1'b0;
    rd(ST_LS_IN);
    chk("load share word", 16'h0b0b, d);
    foreach (gap[i]) begin
      rd(gap[i]);
      chk("unused word", ZERO_W, d);
    end
    rd(ST_ILIM);
    chk("limit word", MAXLIM - GAIN * (DERATE_VAC - 16'h0064), d);
    sendRec(DERATE_VAC);
    chk("full limit", MAXLIM, currentLimit);
  endtask : testTables
  task automatic waitTick();
    @(negedge clk);
    for (int n = 0; n < 45000 && medTick !== 1'b1; n++) @(negedge clk);
  endtask : waitTick
  task automatic testSec();
    logic [7:0] n0;
    @(posedge clk);
    {outVoltage, loadCurrent, pfcCtrlFlag, stall} <= {16'h0c00, 16'h0040, 16'h00a5, 1'b1};
    waitTick();
    n0 = rxCount;
    cyc(12);
    @(negedge clk);
    chk("stalled count", n0, rxCount);
    @(posedge clk);
    stall <= 1'b0;
    cyc(12);
    @(negedge clk);
    chk("record count", n0 + 8'h03, rxCount);
    chk("record words", {16'h0c00, 16'h0040, 16'h00a5}, rxWords);
    waitTick();
    cyc(12);
    @(negedge clk);
    chk("second record", n0 + 8'h06, rxCount);
  endtask : testSec
  task automatic load(input int n, input logic [15:0] i);
    @(posedge clk);
    loadCurrent <= i;
    cyc(n);
    @(negedge clk);
  endtask : load
  task automatic testTrips();
    load(30, 16'h0120);
    load(5, 16'h0080);
    load(30, 16'h0120);
    chk("output after short overloads", 1, outputEnable);
    load(30, 16'h0120);
    chk("output after long overload", 0, outputEnable);
    rd(ST_FAULT);
    chk("fault word", 3'b011, d[2:0]);
    rd(ST_LIMCNT);
    chk("limit count", 16'h0002, d);
    load(1, 16'h0000);
    doReset();
    chk("output after reset", 1, outputEnable);
    @(posedge clk);
    tempB <= 16'h0051;
    cyc(6);
    @(negedge clk);
    chk("thermal trip", 0, outputEnable);
    rd(ST_FAULT);
    chk("thermal fault word", 3'b101, d[2:0]);
  endtask : testTrips
  initial begin
    rst_n = 1'b0;
    {miscWr, pwmEventPin, sendGo, stall, miscAddr, statAddr} = '0;
    {loadCurrent, outVoltage, pfcCtrlFlag, miscIdx, vrms} = '0;
    {tempA, tempB, tempC} = {3{16'h0020}};
    maxCurrentLimit = MAXLIM;
    doReset();
    testSched();
    testFans();
    testTables();
    testSec();
    testTrips();
    conclude();
  end
  // Two medium periods dominate the run, plus margin
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    conclude();
  end
endmodule : sst_supervisor_test
`default_nettype wire
